// File: inc/ldi2c_if.sv
/*
  Two-wire link between the master end and the slave end.
  The interface itself resolves the open-drain wires from the enables below.
*/
`timescale 1ns/100ps
interface ldi2c_if;
  logic scl_oe;
  logic sda_m_oe;
  logic sda_s_oe;
  logic scl;
  logic sda;
  // Wired-AND of the open-drain drivers, pulled up when nobody drives low.
  assign scl = ~scl_oe;
  assign sda = ~(sda_m_oe | sda_s_oe);
  modport master (output scl_oe, output sda_m_oe, input scl, input sda);
  modport slave (output sda_s_oe, input scl, input sda);
endinterface : ldi2c_if

// File: inc/ldi2c_pkg.sv
/*
  Shared constants for the two-wire slave port and its matching bus master.
  Assumes a single 200 MHz system clock on both ends of the link.
*/
package ldi2c_pkg;
  // Link clock divider: a bit has four quarters of 16 cycles, so the serial clock runs at 3.125 MHz.
  // That keeps the link under the 3.4 MHz ceiling that the slave end is built for.
  localparam int unsigned CLK_HZ = 200000000;
  localparam int unsigned SCL_HZ = 3125000;
  localparam int unsigned HALF_CNT = CLK_HZ / (4 * SCL_HZ);
  localparam logic [3:0] HALF_LAST = 4'(HALF_CNT - 1);
  // Power-up address and the address bits that the strap load fills.
  localparam logic [6:0] ADDR_RESET = 7'h00;
  localparam int unsigned SEL_LSB = 0;
  localparam int unsigned SEL_W = 2;
  // Direction bit values of the address byte.
  localparam logic DIR_READ = 1'b1;
  localparam logic DIR_WRITE = 1'b0;
  // Register pointer that triggers the one-shot self-address load.
  localparam logic [7:0] CMD_SELF_ADDR = 8'h2D;
  localparam int unsigned BYTE_W = 8;
  localparam int unsigned BUF_DEPTH = 2;
endpackage : ldi2c_pkg

// File: rtl/ldi2c_master.sv
/*
  Master end of the two-wire link: makes the serial clock, START, STOP and bytes.
  Assumes a user issues one byte command at a time and waits for o_done.
*/
`timescale 1ns/100ps
module ldi2c_master (
  input wire logic i_ref_clk,
  input wire logic i_rst,
  ldi2c_if.master link,
  input wire logic i_cmd_valid,
  output logic o_cmd_ready,
  input wire logic i_start,
  input wire logic i_stop,
  input wire logic i_read,
  input wire logic i_last,
  input wire logic [7:0] i_data,
  output logic o_done,
  output logic [7:0] o_data,
  output logic o_ack
);
  typedef enum logic [2:0] {
    LDI2CM_IDLE = 3'b000,
    LDI2CM_START = 3'b001,
    LDI2CM_BITS = 3'b010,
    LDI2CM_STOP = 3'b011,
    LDI2CM_DONE = 3'b100
  } ldi2cm_state_e;

  ldi2cm_state_e state;
  logic [3:0] div;
  logic [1:0] phase;
  logic [3:0] bit_cnt;
  logic [7:0] tx;
  logic rd;
  logic last;
  logic stop_after;
  logic [1:0] sda_sync;

  wire tick = (div == ldi2c_pkg::HALF_LAST);

  // Divider making the serial clock; the master alone owns it.
  always_ff @(posedge i_ref_clk) begin
    if (i_rst || state == LDI2CM_IDLE) begin
      div <= 4'h0;
    end else begin
      div <= tick ? 4'h0 : div + 4'h1;
    end
  end

  // Returned data is a foreign-domain level and passes two flip-flops.
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      sda_sync <= 2'h3;
    end else begin
      sda_sync <= {sda_sync[0], link.sda};
    end
  end

  assign o_cmd_ready = (state == LDI2CM_IDLE);

  // Each bit has four quarters: clock low-setup, rise, high-sample, fall.
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      state <= LDI2CM_IDLE;
      link.scl_oe <= 1'b0;
      link.sda_m_oe <= 1'b0;
      phase <= 2'h0;
      bit_cnt <= 4'h0;
      tx <= 8'h00;
      rd <= 1'b0;
      last <= 1'b0;
      stop_after <= 1'b0;
      o_done <= 1'b0;
      o_data <= 8'h00;
      o_ack <= 1'b0;
    end else begin
      o_done <= 1'b0;
      case (state)
        LDI2CM_IDLE: if (i_cmd_valid) begin
          tx <= i_data;
          rd <= i_read;
          last <= i_last;
          stop_after <= i_stop;
          bit_cnt <= 4'h0;
          phase <= 2'h0;
          state <= i_start ? LDI2CM_START : LDI2CM_BITS;
        end
        LDI2CM_START: if (tick) begin
          phase <= phase + 2'h1;
          case (phase)
            2'h0: link.sda_m_oe <= 1'b0;
            2'h1: link.scl_oe <= 1'b0;
            2'h2: link.sda_m_oe <= 1'b1;
            default: begin
              link.scl_oe <= 1'b1;
              state <= LDI2CM_BITS;
            end
          endcase
        end
        LDI2CM_BITS: if (tick) begin
          phase <= phase + 2'h1;
          case (phase)
            2'h0: link.sda_m_oe <= (bit_cnt == 4'h8) ? (rd & ~last) : (~rd & ~tx[7]);
            2'h1: link.scl_oe <= 1'b0;
            2'h2: if (bit_cnt == 4'h8) begin
              o_ack <= ~sda_sync[1];
            end else begin
              o_data <= {o_data[6:0], sda_sync[1]};
            end
            default: begin
              link.scl_oe <= 1'b1;
              tx <= {tx[6:0], 1'b0};
              bit_cnt <= bit_cnt + 4'h1;
              if (bit_cnt == 4'h8) begin
                state <= stop_after ? LDI2CM_STOP : LDI2CM_DONE;
              end
            end
          endcase
        end
        LDI2CM_STOP: if (tick) begin
          phase <= phase + 2'h1;
          case (phase)
            2'h0: link.sda_m_oe <= 1'b1;
            2'h1: link.scl_oe <= 1'b0;
            2'h2: link.sda_m_oe <= 1'b0;
            default: state <= LDI2CM_DONE;
          endcase
        end
        LDI2CM_DONE: begin
          o_done <= 1'b1;
          state <= LDI2CM_IDLE;
        end
        default: state <= LDI2CM_IDLE;
      endcase
    end
  end
endmodule : ldi2c_master

// File: rtl/ldi2c_slave.sv
/*
  Slave end of the two-wire port: address match, command pointer, write and read data.
  Assumes the link pins come from another domain and the user side runs on i_ref_clk.
*/
`timescale 1ns/100ps
module ldi2c_slave (
  input wire logic i_ref_clk,
  input wire logic i_rst,
  ldi2c_if.slave link,
  input wire logic i_device_select_bit_low,
  input wire logic i_device_select_bit_high,
  output logic o_wr_valid,
  input wire logic i_wr_ready,
  output logic [7:0] o_wr_reg,
  output logic [7:0] o_wr_data,
  output logic [7:0] o_rd_reg,
  input wire logic [7:0] i_rd_data,
  output logic [6:0] o_address,
  output logic o_busy
);
  typedef enum logic [2:0] {
    LDI2C_IDLE = 3'b000,
    LDI2C_ADDR = 3'b001,
    LDI2C_CMD = 3'b010,
    LDI2C_WDATA = 3'b011,
    LDI2C_RDATA = 3'b100,
    LDI2C_SKIP = 3'b101
  } ldi2c_state_e;

  ldi2c_state_e state;
  logic [1:0] scl_sync;
  logic [1:0] sda_sync;
  logic scl_d;
  logic sda_d;
  logic [7:0] shift;
  logic [3:0] bit_cnt;
  logic ack_phase;
  logic drive_low;
  logic [7:0] ptr;
  logic [7:0] buf_data [0:1];
  logic [7:0] buf_reg [0:1];
  logic buf_wp;
  logic buf_rp;
  logic [1:0] buf_cnt;
  logic rd_nack;
  logic [1:0] sel_meta;
  logic [1:0] sel_sync;

  // Two flip-flops on each pin; edges are found only after the second stage.
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      scl_sync <= 2'h3;
      sda_sync <= 2'h3;
      scl_d <= 1'b1;
      sda_d <= 1'b1;
      sel_meta <= 2'h0;
      sel_sync <= 2'h0;
    end else begin
      scl_sync <= {scl_sync[0], link.scl};
      sda_sync <= {sda_sync[0], link.sda};
      scl_d <= scl_sync[1];
      sda_d <= sda_sync[1];
      // Strap pins are foreign levels too; they get the same two flip-flops and nothing more.
      sel_meta <= {i_device_select_bit_high, i_device_select_bit_low};
      sel_sync <= sel_meta;
    end
  end

  wire scl_rise = scl_sync[1] & ~scl_d;
  wire scl_fall = ~scl_sync[1] & scl_d;
  // A data edge with clock held high is a bus condition, never data.
  wire start_det = scl_sync[1] & scl_d & sda_d & ~sda_sync[1];
  wire stop_det = scl_sync[1] & scl_d & ~sda_d & sda_sync[1];
  wire buf_full = (buf_cnt == 2'(ldi2c_pkg::BUF_DEPTH));
  wire byte_done = scl_fall & (bit_cnt == 4'h8) & ~ack_phase;

  // Main protocol sequencer; START at any moment restarts at the address byte.
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      state <= LDI2C_IDLE;
      bit_cnt <= 4'h0;
      ack_phase <= 1'b0;
      shift <= 8'h00;
      rd_nack <= 1'b0;
    end else if (start_det) begin
      state <= LDI2C_ADDR;
      bit_cnt <= 4'h0;
      ack_phase <= 1'b0;
    end else if (stop_det) begin
      state <= LDI2C_IDLE;
    end else if (state != LDI2C_IDLE && state != LDI2C_SKIP) begin
      if (scl_rise && !ack_phase && state != LDI2C_RDATA) begin
        shift <= {shift[6:0], sda_sync[1]};
        bit_cnt <= bit_cnt + 4'h1;
      end else if (scl_rise && !ack_phase) begin
        bit_cnt <= bit_cnt + 4'h1;
      end else if (scl_rise && ack_phase && state == LDI2C_RDATA) begin
        rd_nack <= sda_sync[1];
      end
      if (byte_done) begin
        ack_phase <= 1'b1;
        bit_cnt <= 4'h0;
        if (state == LDI2C_ADDR && shift[7:1] != o_address) begin
          state <= LDI2C_SKIP;
        end
      end else if (scl_fall && ack_phase) begin
        ack_phase <= 1'b0;
        case (state)
          LDI2C_ADDR: state <= (shift[0] == ldi2c_pkg::DIR_READ) ? LDI2C_RDATA : LDI2C_CMD;
          LDI2C_CMD: state <= LDI2C_WDATA;
          LDI2C_WDATA: state <= LDI2C_WDATA;
          LDI2C_RDATA: state <= rd_nack ? LDI2C_SKIP : LDI2C_RDATA;
          default: state <= LDI2C_SKIP;
        endcase
      end
    end
  end

  // Register pointer: set by the command byte, advanced at the end of each accepted or sent data byte.
  // Advancing before the acknowledge clock falls lets the next read byte's first bit see the next register.
  // A write byte refused for a full buffer leaves the pointer where it was.
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      ptr <= 8'h00;
    end else if (byte_done && state == LDI2C_CMD) begin
      ptr <= shift;
    end else if (byte_done && ((state == LDI2C_WDATA && !buf_full) || state == LDI2C_RDATA)) begin
      ptr <= ptr + 8'h01;
    end
  end

  // Self-address load: straps pass only the synchroniser, with no debounce, so they must be fixed wiring.
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      o_address <= ldi2c_pkg::ADDR_RESET;
    end else if (byte_done && state == LDI2C_CMD && shift == ldi2c_pkg::CMD_SELF_ADDR) begin
      o_address[ldi2c_pkg::SEL_LSB +: ldi2c_pkg::SEL_W] <=
        sel_sync;
    end
  end

  // Two-entry write buffer; a byte arriving while full is not acknowledged.
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      buf_wp <= 1'b0;
      buf_rp <= 1'b0;
      buf_cnt <= 2'h0;
    end else begin
      if (byte_done && state == LDI2C_WDATA && !buf_full) begin
        buf_data[buf_wp] <= shift;
        buf_reg[buf_wp] <= ptr;
        buf_wp <= ~buf_wp;
      end
      if (o_wr_valid && i_wr_ready) begin
        buf_rp <= ~buf_rp;
      end
      buf_cnt <= buf_cnt + 2'((byte_done && state == LDI2C_WDATA && !buf_full) ? 1 : 0)
                 - 2'((o_wr_valid && i_wr_ready) ? 1 : 0);
    end
  end

  assign o_wr_valid = (buf_cnt != 2'h0);
  assign o_wr_data = buf_data[buf_rp];
  assign o_wr_reg = buf_reg[buf_rp];
  assign o_rd_reg = ptr;
  assign o_busy = (state != LDI2C_IDLE);

  // Data-line driver, changed only while the clock is low so it stays stable when high.
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      drive_low <= 1'b0;
    end else if (start_det || stop_det) begin
      drive_low <= 1'b0;
    end else if (byte_done) begin
      drive_low <= (state == LDI2C_ADDR && shift[7:1] == o_address) || state == LDI2C_CMD
                   || (state == LDI2C_WDATA && !buf_full);
    end else if (scl_fall && ack_phase && state == LDI2C_ADDR && shift[0] == ldi2c_pkg::DIR_READ) begin
      drive_low <= ~i_rd_data[7];
    end else if (scl_fall && ack_phase && state == LDI2C_RDATA && !rd_nack) begin
      drive_low <= ~i_rd_data[7];
    end else if (scl_fall && ack_phase) begin
      drive_low <= 1'b0;
    end else if (scl_fall && state == LDI2C_RDATA && !ack_phase && bit_cnt != 4'h8) begin
      drive_low <= ~i_rd_data[3'(4'h7 - bit_cnt)];
    end
  end

  assign link.sda_s_oe = drive_low;
endmodule : ldi2c_slave

// File: test/ldi2c_link_sva.sv
/*
  Checker for the two-wire link that joins the master end and the slave end.
  Assumes it sees the interface wires, the system clock and the synchronous reset.
*/
`timescale 1ns/100ps
module ldi2c_link_sva (
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic scl_oe,
  input wire logic sda_m_oe,
  input wire logic sda_s_oe,
  input wire logic scl,
  input wire logic sda
);
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);
  logic scl_q;
  logic sda_q;
  logic cond_start;
  logic cond_stop;
  logic [3:0] rises;
  // Previous wire levels, so that control conditions can be told from data bits.
  always_ff @(posedge i_ref_clk) begin
    scl_q <= scl;
    sda_q <= sda;
  end
  assign cond_start = scl && scl_q && sda_q && !sda;
  assign cond_stop = scl && scl_q && !sda_q && sda;
  // Clock rises since the last condition; the rise that sets up a stop or repeated start leaves one over.
  always_ff @(posedge i_ref_clk) begin
    if (i_rst || cond_start || cond_stop) begin
      rises <= 4'h0;
    end else if (scl && !scl_q) begin
      rises <= (rises == 4'h8) ? 4'h0 : rises + 4'h1;
    end
  end
  a_idle_after_reset: assert property (!i_rst && $past(i_rst) |-> !scl_oe && !sda_m_oe && !sda_s_oe)
    else $error("link not idle after reset");
  a_slave_sda_steady: assert property (scl && $past(scl) |-> $stable(sda_s_oe))
    else $error("slave moved data while clock high");
  a_ack_held_high: assert property ($rose(scl) && sda_s_oe |-> sda_s_oe [*4])
    else $error("slave low level not held through clock high");
  a_scl_high_len: assert property ($rose(scl) |-> scl [*4])
    else $error("clock high phase too short");
  a_scl_low_len: assert property ($fell(scl) |-> !scl [*4])
    else $error("clock low phase too short");
  a_stop_bit_count: assert property (cond_stop |-> rises == 4'h1)
    else $error("stop not on a byte boundary");
  a_start_bit_count: assert property (cond_start |-> rises <= 4'h1)
    else $error("repeated start not on a byte boundary");
  a_stop_slave_quiet: assert property (cond_stop |-> !sda_s_oe [*4])
    else $error("slave drives data after stop");
endmodule : ldi2c_link_sva

// File: test/tb_top.sv
/*
  Self-checking bench: master end and slave end joined by the link interface.
  Assumes the master user side takes one byte command at a time and pulses done.
*/
`timescale 1ns/100ps
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin errors++; $display("MISMATCH %s exp %0h got %0h", n, e, g); end end
module tb_top;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic cmd_valid, cmd_ready, start, stop, read, last, done, mack;
  logic [7:0] data, mdata, wr_reg, wr_data, rd_reg, rd_data;
  logic sel_lo, sel_hi, wr_ready, wr_valid, busy;
  logic [6:0] address;
  logic [15:0] wq[$];
  int errors = 0;
  int checked = 0;
  ldi2c_if lnk();
  ldi2c_master ldi2c_master_i (.i_ref_clk(clk), .i_rst(rst), .link(lnk), .i_cmd_valid(cmd_valid),
    .o_cmd_ready(cmd_ready), .i_start(start), .i_stop(stop), .i_read(read), .i_last(last), .i_data(data),
    .o_done(done), .o_data(mdata), .o_ack(mack));
  ldi2c_slave ldi2c_slave_i (.i_ref_clk(clk), .i_rst(rst), .link(lnk), .i_device_select_bit_low(sel_lo),
    .i_device_select_bit_high(sel_hi), .o_wr_valid(wr_valid), .i_wr_ready(wr_ready), .o_wr_reg(wr_reg),
    .o_wr_data(wr_data), .o_rd_reg(rd_reg), .i_rd_data(rd_data), .o_address(address), .o_busy(busy));
  ldi2c_link_sva ldi2c_link_sva_i (.i_ref_clk(clk), .i_rst(rst), .scl_oe(lnk.scl_oe), .sda_m_oe(lnk.sda_m_oe),
    .sda_s_oe(lnk.sda_s_oe), .scl(lnk.scl), .sda(lnk.sda));
  // Register file stand-in: each register reads back as its inverted pointer.
  assign rd_data = ~rd_reg;
  always #2.5 clk = ~clk;
  // Collect every accepted write as pointer and data.
  always @(posedge clk) begin
    if (wr_valid === 1'b1 && wr_ready) wq.push_back({wr_reg, wr_data});
  end
  task automatic test_done();
    if (errors == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : test_done
  // One byte command; valid is dropped after one edge since ready stands high when idle.
  task automatic mcmd(input logic s, input logic p, input logic r, input logic l, input logic [7:0] d);
    @(negedge clk);
    {cmd_valid, start, stop, read, last, data} = {1'b1, s, p, r, l, d};
    @(negedge clk);
    cmd_valid = 1'b0;
    `CHK("cmd_taken", 1'b0, cmd_ready)
    do @(negedge clk); while (done !== 1'b1);
  endtask : mcmd
  task automatic chk_wq(input logic [15:0] e);
    logic [15:0] g;
    g = (wq.size() > 0) ? wq.pop_front() : 16'hXXXX;
    `CHK("write", e, g)
  endtask : chk_wq
  // Two data bytes at the power-up address land in consecutive registers.
  task automatic t_write();
    mcmd(1, 0, 0, 0, 8'h00);
    `CHK("addr_ack", 1'b1, mack)
    `CHK("busy", 1'b1, busy)
    mcmd(0, 0, 0, 0, 8'h05);
    `CHK("cmd_ack", 1'b1, mack)
    mcmd(0, 0, 0, 0, 8'h11);
    mcmd(0, 1, 0, 0, 8'h22);
    `CHK("data_ack", 1'b1, mack)
    chk_wq(16'h0511);
    chk_wq(16'h0622);
    mcmd(1, 1, 0, 0, 8'h20);
    `CHK("foreign_nack", 1'b0, mack)
    `CHK("idle", 1'b0, busy)
  endtask : t_write
  // A stalled receiver fills the buffer; the third byte is refused and nothing is lost.
  task automatic t_full();
    wr_ready = 1'b0;
    mcmd(1, 0, 0, 0, 8'h00);
    mcmd(0, 0, 0, 0, 8'h10);
    mcmd(0, 0, 0, 0, 8'hA1);
    mcmd(0, 0, 0, 0, 8'hA2);
    `CHK("second_ack", 1'b1, mack)
    mcmd(0, 1, 0, 0, 8'hA3);
    `CHK("full_nack", 1'b0, mack)
    wr_ready = 1'b1;
    repeat (8) @(negedge clk);
    chk_wq(16'h10A1);
    chk_wq(16'h11A2);
    `CHK("drained", 1'b0, wr_valid)
  endtask : t_full
  // Self-address load from the straps, then the old address goes unanswered.
  task automatic t_self();
    mcmd(1, 0, 0, 0, 8'h00);
    mcmd(0, 1, 0, 0, ldi2c_pkg::CMD_SELF_ADDR);
    `CHK("address", 7'h02, address)
    mcmd(1, 1, 0, 0, 8'h00);
    `CHK("old_nack", 1'b0, mack)
  endtask : t_self
  // Pointer write, repeated start with read direction, two bytes with the last not acknowledged.
  // The pointer's increment flips its top bit, so a stale first bit of the second byte shows up.
  task automatic t_read();
    mcmd(1, 0, 0, 0, 8'h04);
    mcmd(0, 0, 0, 0, 8'h7F);
    mcmd(1, 0, 0, 0, {7'h02, ldi2c_pkg::DIR_READ});
    `CHK("rd_addr_ack", 1'b1, mack)
    mcmd(0, 0, 1, 0, 8'h00);
    `CHK("byte0", 8'h80, mdata)
    mcmd(0, 1, 1, 1, 8'h00);
    `CHK("byte1", 8'h7F, mdata)
    `CHK("sda_idle", 1'b1, lnk.sda)
    `CHK("scl_idle", 1'b1, lnk.scl)
  endtask : t_read
  // Straps are fixed wiring, so they are set once and never switched.
  initial begin
    {cmd_valid, start, stop, read, last, data} = '0;
    {sel_hi, sel_lo, wr_ready} = 3'b101;
    repeat (3) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    repeat (4) @(negedge clk);
    `CHK("reset_addr", 7'h00, address)
    t_write();
    t_full();
    t_self();
    t_read();
    test_done();
  end
  // Cuts a hang short well beyond the expected run of some twenty bytes.
  initial begin
    repeat (60000) @(posedge clk);
    errors++;
    test_done();
  end
endmodule : tb_top
